// ---- logic/scc_pkg.sv ----
package scc_pkg;

  // ************************************************************
  // coprocessor register numbers and opcode fields
  // ************************************************************
  localparam logic [3:0] CRN_CONTROL   = 4'h1;
  localparam logic [3:0] CRN_CORE_CTRL = 4'h7;
  localparam logic [3:0] CRN_TRACE_PID = 4'hD;
  localparam logic [3:0] CRN_TEST      = 4'hF;
  localparam logic [3:0] CRM_ZERO      = 4'h0;
  localparam logic [3:0] CRM_ONE       = 4'h1;
  localparam logic [3:0] CRM_ALT_WFI   = 4'h8;
  localparam logic [3:0] CRM_DRAIN     = 4'hA;
  localparam logic [2:0] OP1_TEST      = 3'h1;
  localparam logic [2:0] OP2_ZERO      = 3'h0;
  localparam logic [2:0] OP2_WFI       = 3'h4;
  localparam logic [2:0] OP2_ALT_WFI   = 3'h2;
  localparam logic [2:0] OP2_CFG       = 3'h0;
  localparam logic [2:0] OP2_SELF_TEST = 3'h1;

  // ************************************************************
  // global control fields
  // ************************************************************
  localparam int CTL_LOAD_PC  = 15;
  localparam int CTL_HIVEC    = 13;
  localparam int CTL_IMEM_EN  = 12;
  localparam int CTL_BIG_END  = 7;
  localparam int CTL_WBUF_EN  = 3;
  localparam int CTL_DMEM_EN  = 2;
  localparam int CTL_ALIGN    = 1;
  localparam logic [31:0] CTL_ONES_MASK = 32'h0000_0F70;

  // ************************************************************
  // configuration control fields and reset
  // ************************************************************
  localparam int CFG_IMEM_ORDER = 18;
  localparam int CFG_DMEM_ORDER = 17;
  localparam int CFG_PREFETCH_OFF = 16;
  localparam int CFG_FIQ_MASK = 2;
  localparam int CFG_IRQ_MASK = 1;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h0007_0006;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0004;

  // ************************************************************
  // self-test control fields
  // ************************************************************
  localparam int ST_I_SIZE_LSB = 21;
  localparam int ST_I_DONE  = 20;
  localparam int ST_I_FAIL  = 19;
  localparam int ST_I_EN    = 18;
  localparam int ST_I_PAUSE = 17;
  localparam int ST_I_RUN   = 16;
  localparam int ST_D_SIZE_LSB = 5;
  localparam int ST_D_DONE  = 4;
  localparam int ST_D_FAIL  = 3;
  localparam int ST_D_EN    = 2;
  localparam int ST_D_PAUSE = 1;
  localparam int ST_D_RUN   = 0;
  localparam int ST_SIZE_W  = 11;
  localparam logic [10:0] ST_SIZE_RESET = 11'h000;

  // ************************************************************
  // stall states
  // ************************************************************
  typedef enum logic [2:0] {
    SCC_RUN   = 3'b001,
    SCC_WFI   = 3'b010,
    SCC_DRAIN = 3'b100
  } scc_state_t;

endpackage

// ---- logic/scc_regs.sv ----
`timescale 1ns/1ns
// Overview of operation
// - bit 15 stops pc load setting state bit
// - bit 13 high vectors, reset from pin
// - bit 12 instruction memory enable, reset pin
// - bit 2 data memory enable, reset pin
// - bit 7 big endian, reset clear
// - bit 3 write buffer enable, reset clear
// - bit 1 alignment check enable, reset clear
// - register 7 or 15 encodings enter wait
// - either interrupt wakes unless its mask bit is set and fifo full
// - debug wake only when debug enabled
// - core takes interrupt or debug after wake
// - drain stalls until both buffers empty
// - trace id driven out, write pulses once
// - register 15 opcode fields select registers
// - bits 18 17 order local memory reads
// - bit 16 disables prefetch buffer
// - bits 2 1 block wake on fifo full
// - self-test start bits and status readback
// - reset clears self-test bits, size fields included
// - self-test enable clears memory enable
// - size n tests two to n+2 bytes
module scc_regs #(
  parameter bit IMEM_TEST_PRESENT = 1'b1,
  parameter bit DMEM_TEST_PRESENT = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cp_write,
  input  wire logic        cp_read,
  input  wire logic [2:0]  cp_opcode1,
  input  wire logic [3:0]  cp_crn,
  input  wire logic [3:0]  cp_crm,
  input  wire logic [2:0]  cp_opcode2,
  input  wire logic [31:0] cp_wdata,
  input  wire logic        high_vector_boot_pin,
  input  wire logic        memory_boot_enable_pin,
  input  wire logic        fast_interrupt_request_n,
  input  wire logic        normal_interrupt_request_n,
  input  wire logic        external_debug_request,
  input  wire logic        debug_request_bit,
  input  wire logic        debug_enable_input,
  input  wire logic        trace_fifo_full,
  input  wire logic        bus_wbuf_empty,
  input  wire logic        mem_wbuf_empty,
  input  wire logic        imem_test_done,
  input  wire logic        imem_test_fail,
  input  wire logic        dmem_test_done,
  input  wire logic        dmem_test_fail,
  output logic [31:0]      cp_rdata,
  output logic             core_clk_en,
  output logic             exec_stall,
  output logic             debug_wake,
  output logic [31:0]      global_control,
  output logic [31:0]      configuration_control,
  output logic [31:0]      self_test_control,
  output logic [31:0]      trace_process_id_out,
  output logic             trace_process_id_write_pulse,
  output logic             imem_test_start,
  output logic             dmem_test_start
);

  // ************************************************************
  // decode
  // ************************************************************
  wire sel_ctl  = cp_crn == scc_pkg::CRN_CONTROL;
  wire sel_pid  = cp_crn == scc_pkg::CRN_TRACE_PID;
  wire sel_test = cp_crn == scc_pkg::CRN_TEST &&
                  cp_opcode1 == scc_pkg::OP1_TEST;
  wire sel_cfg  = sel_test && cp_crm == scc_pkg::CRM_ONE &&
                  cp_opcode2 == scc_pkg::OP2_CFG;
  wire sel_st   = sel_test && cp_crm == scc_pkg::CRM_ZERO &&
                  cp_opcode2 == scc_pkg::OP2_SELF_TEST;
  wire wr_ctl   = cp_write && sel_ctl;
  wire wr_pid   = cp_write && sel_pid;
  wire wr_cfg   = cp_write && sel_cfg;
  wire wr_st    = cp_write && sel_st;
  wire wfi_cmd  = cp_write &&
    ((cp_crn == scc_pkg::CRN_CORE_CTRL && cp_crm == scc_pkg::CRM_ZERO &&
      cp_opcode2 == scc_pkg::OP2_WFI) ||
     (cp_crn == scc_pkg::CRN_TEST && cp_crm == scc_pkg::CRM_ALT_WFI &&
      cp_opcode2 == scc_pkg::OP2_ALT_WFI));
  wire drain_cmd = cp_write && cp_crn == scc_pkg::CRN_CORE_CTRL &&
                   cp_crm == scc_pkg::CRM_DRAIN &&
                   cp_opcode2 == scc_pkg::OP2_WFI;

  // ************************************************************
  // wake and self-test next values
  // ************************************************************
  wire fiq_wake = !fast_interrupt_request_n &&
    !(configuration_control[scc_pkg::CFG_FIQ_MASK] && trace_fifo_full);
  wire irq_wake = !normal_interrupt_request_n &&
    !(configuration_control[scc_pkg::CFG_IRQ_MASK] && trace_fifo_full);
  wire dbg_req  = debug_enable_input &&
                  (external_debug_request || debug_request_bit);
  wire wake     = fiq_wake || irq_wake || dbg_req;
  wire bufs_empty = bus_wbuf_empty && mem_wbuf_empty;

  wire i_start = wr_st && cp_wdata[scc_pkg::ST_I_RUN];
  wire d_start = wr_st && cp_wdata[scc_pkg::ST_D_RUN];
  wire i_en_now = wr_st ? cp_wdata[scc_pkg::ST_I_EN]
                        : self_test_control[scc_pkg::ST_I_EN];
  wire d_en_now = wr_st ? cp_wdata[scc_pkg::ST_D_EN]
                        : self_test_control[scc_pkg::ST_D_EN];

  function automatic logic [10:0] size_field(input logic [10:0] v,
                                              input bit present);
    size_field = present ? v : 11'h000;
  endfunction

  logic [31:0] next_ctl;
  logic [31:0] next_st;
  logic        i_run;
  logic        d_run;
  wire         next_i_run = i_start || (i_run && !imem_test_done);
  wire         next_d_run = d_start || (d_run && !dmem_test_done);

  always_comb begin
    next_ctl = global_control;
    if (wr_ctl) begin
      next_ctl = cp_wdata & 32'h0000_B08E;
      next_ctl = next_ctl | scc_pkg::CTL_ONES_MASK;
    end
    if (i_en_now) begin
      next_ctl[scc_pkg::CTL_IMEM_EN] = 1'b0;
    end
    if (d_en_now) begin
      next_ctl[scc_pkg::CTL_DMEM_EN] = 1'b0;
    end
  end

  always_comb begin
    next_st = self_test_control;
    if (wr_st) begin
      next_st[31:21] = size_field(cp_wdata[31:21], IMEM_TEST_PRESENT);
      next_st[15:5]  = size_field(cp_wdata[15:5], DMEM_TEST_PRESENT);
      next_st[scc_pkg::ST_I_EN]    = cp_wdata[scc_pkg::ST_I_EN];
      next_st[scc_pkg::ST_I_PAUSE] = cp_wdata[scc_pkg::ST_I_PAUSE];
      next_st[scc_pkg::ST_D_EN]    = cp_wdata[scc_pkg::ST_D_EN];
      next_st[scc_pkg::ST_D_PAUSE] = cp_wdata[scc_pkg::ST_D_PAUSE];
    end
    if (i_start) begin
      next_st[scc_pkg::ST_I_DONE] = 1'b0;
      next_st[scc_pkg::ST_I_FAIL] = 1'b0;
    end else if (i_run && imem_test_done) begin
      next_st[scc_pkg::ST_I_DONE] = 1'b1;
      next_st[scc_pkg::ST_I_FAIL] = imem_test_fail;
    end
    if (d_start) begin
      next_st[scc_pkg::ST_D_DONE] = 1'b0;
      next_st[scc_pkg::ST_D_FAIL] = 1'b0;
    end else if (d_run && dmem_test_done) begin
      next_st[scc_pkg::ST_D_DONE] = 1'b1;
      next_st[scc_pkg::ST_D_FAIL] = dmem_test_fail;
    end
    next_st[scc_pkg::ST_I_RUN] = next_i_run;
    next_st[scc_pkg::ST_D_RUN] = next_d_run;
  end

  // ************************************************************
  // read mux
  // ************************************************************
  wire [31:0] rd_mux = sel_ctl ? global_control :
                       sel_pid ? trace_process_id_out :
                       sel_cfg ? configuration_control :
                       sel_st  ? self_test_control : 32'h0000_0000;

  // ************************************************************
  // registers
  // ************************************************************
  logic boot_load;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boot_load <= 1'b1;
    end else begin
      boot_load <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      global_control <= scc_pkg::CTL_ONES_MASK;
    end else if (boot_load) begin
      global_control <= scc_pkg::CTL_ONES_MASK |
        {18'h0, high_vector_boot_pin, memory_boot_enable_pin, 9'h0,
         memory_boot_enable_pin, 2'h0};
    end else begin
      global_control <= next_ctl;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      configuration_control <= scc_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      configuration_control <= cp_wdata & scc_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      self_test_control <= {scc_pkg::ST_SIZE_RESET, 5'h00,
                            scc_pkg::ST_SIZE_RESET, 5'h00};
      i_run <= 1'b0;
      d_run <= 1'b0;
      imem_test_start <= 1'b0;
      dmem_test_start <= 1'b0;
    end else begin
      self_test_control <= next_st;
      i_run <= next_i_run;
      d_run <= next_d_run;
      imem_test_start <= i_start;
      dmem_test_start <= d_start;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trace_process_id_out <= 32'h0000_0000;
      trace_process_id_write_pulse <= 1'b0;
    end else begin
      if (wr_pid) begin
        trace_process_id_out <= cp_wdata;
      end
      trace_process_id_write_pulse <= wr_pid;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cp_rdata <= 32'h0000_0000;
    end else if (cp_read) begin
      cp_rdata <= rd_mux;
    end
  end

  // ************************************************************
  // wait and drain stall machine
  // ************************************************************
  scc_pkg::scc_state_t state;
  scc_pkg::scc_state_t next_state;

  always_comb begin
    case (state)
      scc_pkg::SCC_RUN: begin
        if (wfi_cmd) begin
          next_state = scc_pkg::SCC_WFI;
        end else if (drain_cmd) begin
          next_state = scc_pkg::SCC_DRAIN;
        end else begin
          next_state = scc_pkg::SCC_RUN;
        end
      end
      scc_pkg::SCC_WFI:
        next_state = wake ? scc_pkg::SCC_RUN : scc_pkg::SCC_WFI;
      scc_pkg::SCC_DRAIN:
        next_state = bufs_empty ? scc_pkg::SCC_RUN : scc_pkg::SCC_DRAIN;
      default:
        next_state = scc_pkg::SCC_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= scc_pkg::SCC_RUN;
      core_clk_en <= 1'b1;
      exec_stall <= 1'b0;
      debug_wake <= 1'b0;
    end else begin
      state <= next_state;
      core_clk_en <= next_state != scc_pkg::SCC_WFI;
      exec_stall <= next_state == scc_pkg::SCC_DRAIN;
      debug_wake <= state == scc_pkg::SCC_WFI && wake &&
                    !fiq_wake && !irq_wake;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb_chk @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_wfi_entry;
    wfi_cmd && state == scc_pkg::SCC_RUN;
  endsequence

  a_wfi_gates_clock: assert property (
    s_wfi_entry |=> !core_clk_en)
    else $error("clock enable not negated after wait");
  a_irq_wakes_core: assert property (
    state == scc_pkg::SCC_WFI && !normal_interrupt_request_n &&
    !configuration_control[1] |=> core_clk_en)
    else $error("interrupt did not wake core");
  a_debug_gated_wake: assert property (
    state == scc_pkg::SCC_WFI && !debug_enable_input &&
    fast_interrupt_request_n && normal_interrupt_request_n |=> !core_clk_en)
    else $error("debug woke without enable");
  a_drain_holds_stall: assert property (
    exec_stall && !bufs_empty |=> exec_stall)
    else $error("drain stall ended with data buffered");
  a_trace_pulse_once: assert property (
    wr_pid |=> trace_process_id_write_pulse && trace_process_id_out ==
    $past(cp_wdata))
    else $error("trace write pulse or value wrong");
  a_fifo_full_mask: assert property (
    state == scc_pkg::SCC_WFI && trace_fifo_full &&
    configuration_control[2] && configuration_control[1] &&
    !dbg_req |=> !core_clk_en)
    else $error("masked interrupt woke core on full fifo");
  a_test_clears_mem: assert property (
    wr_st && cp_wdata[scc_pkg::ST_D_EN] && !boot_load |=>
    !global_control[scc_pkg::CTL_DMEM_EN])
    else $error("self-test enable left memory enabled");
  a_start_sets_run: assert property (
    i_start |=> self_test_control[scc_pkg::ST_I_RUN] &&
    !self_test_control[scc_pkg::ST_I_DONE])
    else $error("self-test start not reflected");
  a_ctl_write_keeps: assert property (
    wr_ctl && !boot_load && !i_en_now |=>
    global_control[scc_pkg::CTL_BIG_END] == $past(cp_wdata[7]) &&
    global_control[11:8] == 4'hF)
    else $error("control write not stored");

endmodule // scc_regs

// ---- verification/scc_far_side.sv ----
`timescale 1ns/1ns
// ************************************************************
// write buffers and self-test engine model
// ************************************************************
module scc_far_side #(
  parameter int TEST_LAT = 6
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       load_strobe,
  input  wire logic [4:0] bus_load,
  input  wire logic [4:0] mem_load,
  input  wire logic       fail_i,
  input  wire logic       fail_d,
  input  wire logic       imem_test_start,
  input  wire logic       dmem_test_start,
  output logic            bus_wbuf_empty,
  output logic            mem_wbuf_empty,
  output logic            imem_test_done,
  output logic            imem_test_fail,
  output logic            dmem_test_done,
  output logic            dmem_test_fail
);
  logic [4:0] bus_cnt;
  logic [4:0] mem_cnt;
  int         i_cnt;
  int         d_cnt;
  logic       tgl;
  // buffers keep draining during a wait stall
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_cnt <= '0;
      mem_cnt <= '0;
      i_cnt   <= 0;
      d_cnt   <= 0;
      tgl     <= 1'b0;
    end else begin
      bus_cnt <= load_strobe ? bus_load : bus_cnt - 5'(bus_cnt != 0);
      mem_cnt <= load_strobe ? mem_load : mem_cnt - 5'(mem_cnt != 0);
      i_cnt   <= imem_test_start ? TEST_LAT : i_cnt - int'(i_cnt != 0);
      d_cnt   <= dmem_test_start ? TEST_LAT : d_cnt - int'(d_cnt != 0);
      tgl     <= ~tgl;
    end
  end
  assign bus_wbuf_empty = (bus_cnt == 5'h00);
  assign mem_wbuf_empty = (mem_cnt == 5'h00);
  assign imem_test_done = (i_cnt == 1);
  assign dmem_test_done = (d_cnt == 1);
  // fail is meaningless outside done, so it wanders
  assign imem_test_fail = imem_test_done ? fail_i : tgl;
  assign dmem_test_fail = dmem_test_done ? fail_d : ~tgl;
endmodule // scc_far_side

// ---- verification/scc_tb.sv ----
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module tb;
  logic ref_clk, rst, cp_write, cp_read, core_clk_en, exec_stall, debug_wake;
  logic [2:0] cp_opcode1, cp_opcode2;
  logic [3:0] cp_crn, cp_crm;
  logic [31:0] cp_wdata, cp_rdata, global_control, configuration_control;
  logic [31:0] self_test_control, trace_process_id_out, tid, d;
  logic high_vector_boot_pin, memory_boot_enable_pin, trace_fifo_full;
  logic fast_interrupt_request_n, normal_interrupt_request_n;
  logic external_debug_request, debug_request_bit, debug_enable_input;
  logic bus_wbuf_empty, mem_wbuf_empty, imem_test_done, imem_test_fail;
  logic dmem_test_done, dmem_test_fail, trace_process_id_write_pulse;
  logic imem_test_start, dmem_test_start, load_strobe, fail_i, fail_d;
  logic [4:0] bus_load, mem_load;
  logic probe, rd_seen, a, b;
  logic [38:0] e;
  logic [38:0] exp_q[$];
  int fail_count, total_checks, n;

  scc_regs DUT (.ref_clk, .rst, .cp_write, .cp_read, .cp_opcode1, .cp_crn,
    .cp_crm, .cp_opcode2, .cp_wdata, .high_vector_boot_pin,
    .memory_boot_enable_pin, .fast_interrupt_request_n,
    .normal_interrupt_request_n, .external_debug_request, .debug_request_bit,
    .debug_enable_input, .trace_fifo_full, .bus_wbuf_empty, .mem_wbuf_empty,
    .imem_test_done, .imem_test_fail, .dmem_test_done, .dmem_test_fail,
    .cp_rdata, .core_clk_en, .exec_stall, .debug_wake, .global_control,
    .configuration_control, .self_test_control, .trace_process_id_out,
    .trace_process_id_write_pulse, .imem_test_start, .dmem_test_start);
  scc_far_side far (.ref_clk, .rst, .load_strobe, .bus_load, .mem_load,
    .fail_i, .fail_d, .imem_test_start, .dmem_test_start, .bus_wbuf_empty,
    .mem_wbuf_empty, .imem_test_done, .imem_test_fail, .dmem_test_done,
    .dmem_test_fail);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // result watcher
  // ************************************************************
  always @(posedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK(cp_rdata, e[31:0])
    end
    if (probe && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK({trace_process_id_out, core_clk_en, exec_stall, debug_wake,
            trace_process_id_write_pulse, imem_test_start,
            dmem_test_start}, e[37:0])
    end
    rd_seen <= cp_read & ~rst;
  end

  // ************************************************************
  // drivers
  // ************************************************************
  task automatic xfer(bit wr, logic [2:0] o1, logic [3:0] cn, logic [3:0] cm,
                      logic [2:0] o2, logic [31:0] dat);
    {cp_write, cp_read, probe} = {wr, ~wr, 1'b0};
    {cp_opcode1, cp_crn, cp_crm, cp_opcode2, cp_wdata} = {o1, cn, cm, o2, dat};
    @(negedge ref_clk);
  endtask
  task automatic idle();
    {cp_write, cp_read, probe} = 3'b000;
    cp_wdata = ~cp_wdata;
    @(negedge ref_clk);
  endtask
  task automatic rd(logic [2:0] o1, logic [3:0] cn, logic [3:0] cm,
                    logic [2:0] o2, logic [31:0] ex);
    exp_q.push_back({7'h00, ex});
    xfer(1'b0, o1, cn, cm, o2, 32'h0);
  endtask
  task automatic st(logic [5:0] f);
    exp_q.push_back({1'b1, tid, f});
    {cp_write, cp_read, probe} = 3'b001;
    @(negedge ref_clk);
  endtask
  task automatic do_reset(logic hv, logic mb);
    rst = 1'b1;
    high_vector_boot_pin = hv;
    memory_boot_enable_pin = mb;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_for(input bit sel, input logic v);
    n = 0;
    while ((sel ? a : exec_stall) !== v && n < 40) begin
      idle();
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      end_sim();
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    {cp_write, cp_read, cp_opcode1, cp_crn, cp_crm, cp_opcode2} = '0;
    {cp_wdata, tid, probe, rd_seen, trace_fifo_full, load_strobe} = '0;
    {fast_interrupt_request_n, normal_interrupt_request_n} = 2'b11;
    {external_debug_request, debug_request_bit, debug_enable_input} = '0;
    {bus_load, mem_load, fail_i, fail_d} = '0;
    {fail_count, total_checks} = '0;
    void'($urandom(32'h5a2a10ae));
    do_reset(1'b1, 1'b1);
    rd(3'h0, 4'h1, 4'h0, 3'h0, 32'h00003F74);
    rd(3'h1, 4'hF, 4'h1, 3'h0, 32'h00000004);
    rd(3'h1, 4'hF, 4'h0, 3'h1, 32'h00000000);
    st(6'b100000);
    for (int i = 0; i < 8; i++) begin
      d = ($urandom() & 32'h0000B08E) | 32'h00000F70;
      xfer(1'b1, 3'h0, 4'h1, 4'h0, 3'h0, d);
      rd(3'h0, 4'h1, 4'h0, 3'h0, d);
      `CHK(global_control, d)
      d = $urandom() & 32'h00070006;
      xfer(1'b1, 3'h1, 4'hF, 4'h1, 3'h0, d);
      xfer(1'b1, 3'h0, 4'hF, 4'h1, 3'h0, ~d);
      rd(3'h1, 4'hF, 4'h1, 3'h0, d);
      `CHK(configuration_control, d)
    end
    rd(3'h0, 4'h2, 4'h0, 3'h0, 32'h0);
    rd(3'h1, 4'hF, 4'h0, 3'h2, 32'h0);
    tid = $urandom();
    xfer(1'b1, 3'h0, 4'hD, 4'($urandom()), 3'($urandom()), tid);
    st(6'b100100);
    st(6'b100000);
    rd(3'h0, 4'hD, 4'($urandom()), 3'($urandom()), tid);
    xfer(1'b1, 3'h1, 4'hF, 4'h1, 3'h0, 32'h00000006);
    for (int k = 0; k < 8; k++) begin
      if (k < 4) xfer(1'b1, 3'h0, 4'h7, 4'h0, 3'h4, 32'h0);
      else xfer(1'b1, 3'($urandom()), 4'hF, 4'h8, 3'h2, 32'h0);
      st(6'b000000);
      trace_fifo_full = (k % 4 < 2);
      fast_interrupt_request_n = (k % 4 != 0);
      normal_interrupt_request_n = (k % 4 != 1);
      external_debug_request = (k % 4 == 2);
      debug_request_bit = (k % 4 == 3);
      idle();
      st(6'b000000);
      trace_fifo_full = 1'b0;
      debug_enable_input = 1'b1;
      idle();
      st({2'b10, 1'(k % 4 > 1), 3'b000});
      {fast_interrupt_request_n, normal_interrupt_request_n} = 2'b11;
      {external_debug_request, debug_request_bit, debug_enable_input} = '0;
    end
    {bus_load, mem_load, load_strobe} = {5'd5, 5'd9, 1'b1};
    idle();
    load_strobe = 1'b0;
    xfer(1'b1, 3'h0, 4'h7, 4'hA, 3'h4, 32'h0);
    st(6'b110000);
    wait_for(1'b0, 1'b0);
    `CHK(n >= 4, 1'b1)
    st(6'b100000);
    xfer(1'b1, 3'h0, 4'h1, 4'h0, 3'h0, 32'h00001F74);
    {fail_i, fail_d} = 2'b10;
    d = (32'($urandom_range(24, 1)) << 21) | 32'h00050005;
    d = d | (32'($urandom_range(24, 1)) << 5);
    xfer(1'b1, 3'h1, 4'hF, 4'h0, 3'h1, d);
    st(6'b100011);
    rd(3'h1, 4'hF, 4'h0, 3'h1, d);
    rd(3'h0, 4'h1, 4'h0, 3'h0, 32'h00000F70);
    wait_for(1'b1, 1'b1);
    rd(3'h1, 4'hF, 4'h0, 3'h1, (d & ~32'h10001) | 32'h00180010);
    xfer(1'b1, 3'h0, 4'h1, 4'h0, 3'h0, 32'h00001F74);
    rd(3'h0, 4'h1, 4'h0, 3'h0, 32'h00000F70);
    b = 1'($urandom());
    idle();
    do_reset(1'($urandom()), b);
    d = 32'h00000F70 | {18'h0, high_vector_boot_pin, b, 9'h0, b, 2'h0};
    rd(3'h0, 4'h1, 4'h0, 3'h0, d);
    rd(3'h1, 4'hF, 4'h0, 3'h1, 32'h0);
    repeat (2) idle();
    end_sim();
  end
  assign a = self_test_control[20] & self_test_control[4];
endmodule // tb
